//--- design/ubs_map.svh
// Bit positions, command codes, reset values and timing counts of the serial UART core
`ifndef UBS_MAP_SVH
`define UBS_MAP_SVH

// Command codes in the two top bits of each 16-bit host word
`define UBS_CMD_WCFG 2'h3
`define UBS_CMD_RCFG 2'h1
`define UBS_CMD_WDAT 2'h2
`define UBS_CMD_RDAT 2'h0

// Host frame length and word bit positions
`define UBS_FRAME_BITS 5'h10
`define UBS_POS_R 15
`define UBS_POS_T 14
`define UBS_POS_TX_INHIBIT 10
`define UBS_POS_RTS 9
`define UBS_POS_TX_EXTRA 8
`define UBS_POS_RAFE 10
`define UBS_POS_CTS 9
`define UBS_POS_RX_EXTRA 8

// Reset values
`define UBS_RST_TX_EMPTY 1'h1
`define UBS_RST_RTS_N 1'h1
`define UBS_RST_LINE 1'h1

// Timing
`define UBS_CLK_HZ 50000000
`define UBS_WAKE_MS 50
`define UBS_WAKE_CYC ((`UBS_CLK_HZ / 1000) * `UBS_WAKE_MS)
`define UBS_BIT_BASE_CYC 20'h00010

`endif

//--- design/ubs_pkg.sv
// Types shared by the serial UART core and its receive store
package ubs_pkg;

  typedef struct packed {
    logic fifo_dis;
    logic hardware_shutdown_pin;
    logic tm;
    logic rm;
    logic pm;
    logic ram;
    logic ir;
    logic st;
    logic pe;
    logic len7;
    logic [3:0] baud;
  } ubs_cfg_t;

  typedef struct packed {
    logic extra;
    logic [7:0] data;
  } ubs_word_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } ubs_spi_t;

  typedef struct packed {
    logic en;
    logic [2:0] addr;
    ubs_word_t word;
  } ubs_wr_t;

  typedef enum logic [3:0] {
    UBS_RX_IDLE = 4'h1,
    UBS_RX_START = 4'h2,
    UBS_RX_DATA = 4'h4,
    UBS_RX_STOP = 4'h8
  } ubs_rx_st_t;

  typedef enum logic [1:0] {
    UBS_TX_IDLE = 2'h1,
    UBS_TX_SEND = 2'h2
  } ubs_tx_st_t;

  typedef struct packed {
    logic [7:0][8:0] mem;
    ubs_word_t rd;
  } ubs_mem_state_t;

  typedef struct packed {
    ubs_spi_t spi_m;
    ubs_spi_t spi_s;
    ubs_spi_t spi_p;
    logic rx_m;
    logic rx_s;
    logic rx_p;
    logic cts_m;
    logic cts_s;
    logic hw_m;
    logic hw_s;
    logic [15:0] sh_in;
    logic [15:0] out_w;
    logic [4:0] nbit;
    logic [1:0] cmd;
    ubs_cfg_t cfg;
    ubs_cfg_t pend;
    logic pend_v;
    logic shut_p;
    logic [21:0] wake;
    logic osc;
    logic rts_n;
    logic t;
    ubs_word_t tbuf;
    ubs_tx_st_t tst;
    logic [11:0] tsh;
    logic [3:0] tcnt;
    logic [19:0] ttmr;
    logic txo;
    ubs_rx_st_t rst;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic [19:0] rtmr;
    logic rafe;
    logic [3:0] wp;
    logic [3:0] rp;
    logic dout;
    logic irq_n;
    logic hardware_shutdown_pin_rb;
  } ubs_state_t;

endpackage : ubs_pkg

//--- design/ubs_rx_mem.sv
// Eight-entry receive store with registered read data
`timescale 1ns/10ps
module ubs_rx_mem (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire ubs_pkg::ubs_wr_t wr_i,
  input wire logic [2:0] rd_addr_i,
  output ubs_pkg::ubs_word_t rd_data_o
);
  import ubs_pkg::*;

  ubs_mem_state_t s_q;
  ubs_mem_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_i.en) begin
      s_d.mem[wr_i.addr] = wr_i.word;
    end
    s_d.rd = ubs_word_t'(s_q.mem[rd_addr_i]);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rd;

endmodule : ubs_rx_mem

//--- design/ubs_uart_core.sv
// Serial-host UART core: shutdown, stop select, transmit empty flag, inhibit and interrupt mask
// Summary of operation
// - One flag: activity in shutdown, framing otherwise
// - Shutdown: any receive line edge sets activity
// - Zero at first stop bit sets framing error
// - Next good character clears framing error
// - Data read keeps it; configuration write clears it
// - Framing error sends receiver back to idle
// - Shutdown request applied once transmitter empties after deselect, oscillator stops
// - Shutdown entry clears flags, data and receive store
// - Handshake bits untouched by shutdown entry or exit
// - Exit shutdown; oscillator restarts after wake delay
// - Configuration write shutdown readback set only after transmitter empties
// - Hardware shutdown pin sets readback immediately
// - Stop select chooses one or two stop bits
// - Receiver checks only one stop bit
// - Configuration readback returns stop select
// - Transmit empty flag high when buffer free
// - Inhibit set: data write updates handshake only
// - Interrupt low when mask and empty flag set
// - Configuration readback returns transmit empty mask
// - Masks act at 16th edge, others after transmission
`timescale 1ns/10ps
`include "ubs_map.svh"
module ubs_uart_core #(
  parameter int unsigned WAKE_CYC = `UBS_WAKE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire ubs_pkg::ubs_spi_t spi_i,
  output logic dout_o,
  input wire logic rx_i,
  output logic tx_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  input wire logic hw_hardware_shutdown_pin_n_i,
  output logic irq_n_o,
  output logic osc_run_o,
  output logic hardware_shutdown_pin_rb_o
);
  import ubs_pkg::*;

  ubs_state_t s_q;
  ubs_state_t s_d;
  ubs_wr_t wr;
  ubs_word_t rd_data;
  ubs_word_t rxw;
  logic shut;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic r_flag;
  logic push;
  logic pop;
  logic clr;
  logic tx_idle;
  logic [3:0] cnt;
  logic [15:0] word_in;
  logic [19:0] bit_cyc;

  ubs_rx_mem u_rx_mem (
    .clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .wr_i(wr),
    .rd_addr_i(s_q.rp[2:0]),
    .rd_data_o(rd_data)
  );

  always_comb begin
    s_d = s_q;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    wr = '0;
    word_in = {s_q.sh_in[14:0], s_q.spi_s.din};
    cnt = s_q.wp - s_q.rp;
    r_flag = (cnt != 4'h0);
    shut = s_q.cfg.hardware_shutdown_pin | ~s_q.hw_s;
    bit_cyc = `UBS_BIT_BASE_CYC << s_q.cfg.baud;
    cs_fall = s_q.spi_p.cs_n & ~s_q.spi_s.cs_n;
    cs_rise = ~s_q.spi_p.cs_n & s_q.spi_s.cs_n;
    sck_rise = ~s_q.spi_s.cs_n & ~s_q.spi_p.sclk & s_q.spi_s.sclk;
    sck_fall = ~s_q.spi_s.cs_n & s_q.spi_p.sclk & ~s_q.spi_s.sclk;
    if (s_q.cfg.pe) begin
      rxw = {s_q.rsh[8], s_q.rsh[7:0]};
    end else begin
      rxw = {1'b0, s_q.rsh[8:1]};
    end
    if (s_q.cfg.len7) begin
      rxw.data[7] = 1'b0;
    end

    // Input synchronisers
    s_d.spi_m = spi_i;
    s_d.spi_s = s_q.spi_m;
    s_d.spi_p = s_q.spi_s;
    s_d.rx_m = rx_i;
    s_d.rx_s = s_q.rx_m;
    s_d.rx_p = s_q.rx_s;
    s_d.cts_m = cts_n_i;
    s_d.cts_s = s_q.cts_m;
    s_d.hw_m = hw_hardware_shutdown_pin_n_i;
    s_d.hw_s = s_q.hw_m;

    // Host port framing
    if (cs_fall) begin
      s_d.nbit = 5'h00;
      s_d.out_w = {r_flag, s_q.t, 14'h0000};
      s_d.dout = r_flag;
    end
    if (sck_rise && s_q.nbit < `UBS_FRAME_BITS) begin
      s_d.sh_in = word_in;
      s_d.nbit = 5'(s_q.nbit + 5'h01);
      if (s_q.nbit == 5'h01) begin
        s_d.cmd = word_in[1:0];
        if (word_in[1:0] == `UBS_CMD_RCFG) begin
          s_d.out_w[13:0] = {s_q.cfg.fifo_dis, s_q.hardware_shutdown_pin_rb, s_q.cfg[11:0]};
        end else begin
          s_d.out_w[13:0] = {3'h0, s_q.rafe, ~s_q.cts_s, rd_data.extra & r_flag, rd_data.data & {8{r_flag}}};
        end
      end
      if (s_q.nbit == 5'h0F) begin
        if (s_q.cmd == `UBS_CMD_WCFG) begin
          s_d.cfg.tm = word_in[11];
          s_d.cfg.rm = word_in[10];
          s_d.cfg.pm = word_in[9];
          s_d.cfg.ram = word_in[8];
        end else if (s_q.cmd != `UBS_CMD_RCFG) begin
          pop = r_flag;
        end
      end
    end
    if (sck_fall && s_q.nbit < `UBS_FRAME_BITS) begin
      s_d.dout = s_q.out_w[~s_q.nbit[3:0]];
    end

    // Commands act when the host deselects
    if (cs_rise && s_q.nbit == `UBS_FRAME_BITS) begin
      if (s_q.cmd == `UBS_CMD_WCFG) begin
        s_d.pend = ubs_cfg_t'(s_q.sh_in[13:0]);
        s_d.pend_v = 1'b1;
        s_d.rafe = 1'b0;
        clr = 1'b1;
      end else if (s_q.cmd == `UBS_CMD_WDAT) begin
        s_d.rts_n = ~s_q.sh_in[`UBS_POS_RTS];
        if (!s_q.sh_in[`UBS_POS_TX_INHIBIT] && !shut) begin
          s_d.tbuf = {s_q.sh_in[`UBS_POS_TX_EXTRA], s_q.sh_in[7:0]};
          s_d.t = 1'b0;
        end
      end
    end

    // Pending configuration waits for the transmitter to finish
    tx_idle = (s_q.tst == UBS_TX_IDLE) && (s_q.t || shut);
    if (s_d.pend_v && tx_idle) begin
      s_d.cfg = {s_d.pend.fifo_dis, s_d.pend.hardware_shutdown_pin, s_d.cfg[11:8], s_d.pend[7:0]};
      s_d.pend_v = 1'b0;
    end

    // Shutdown entry, exit and oscillator control
    s_d.shut_p = shut;
    s_d.hardware_shutdown_pin_rb = shut;
    if (shut && !s_q.shut_p) begin
      s_d.rafe = 1'b0;
      s_d.t = 1'b0;
      s_d.tbuf = '0;
      s_d.rsh = '0;
      s_d.rst = UBS_RX_IDLE;
      s_d.tst = UBS_TX_IDLE;
      s_d.txo = `UBS_RST_LINE;
      clr = 1'b1;
    end
    if (!shut && s_q.shut_p) begin
      s_d.wake = 22'(WAKE_CYC);
      s_d.t = `UBS_RST_TX_EMPTY;
    end else if (s_q.wake != 22'h000000) begin
      s_d.wake = 22'(s_q.wake - 22'h000001);
    end
    s_d.osc = !shut && (s_d.wake == 22'h000000);

    // Receiver
    if (s_q.osc && !shut) begin
      case (s_q.rst)
        UBS_RX_IDLE: begin
          if (!s_q.rx_s) begin
            s_d.rst = UBS_RX_START;
            s_d.rtmr = bit_cyc >> 1;
          end
        end
        UBS_RX_START: begin
          if (s_q.rtmr != 20'h00000) begin
            s_d.rtmr = 20'(s_q.rtmr - 20'h00001);
          end else if (!s_q.rx_s) begin
            s_d.rst = UBS_RX_DATA;
            s_d.rtmr = 20'(bit_cyc - 20'h00001);
            s_d.rcnt = 4'(4'h8 + {3'h0, s_q.cfg.pe} - {3'h0, s_q.cfg.len7});
            s_d.rsh = '0;
          end else begin
            s_d.rst = UBS_RX_IDLE;
          end
        end
        UBS_RX_DATA: begin
          if (s_q.rtmr != 20'h00000) begin
            s_d.rtmr = 20'(s_q.rtmr - 20'h00001);
          end else begin
            s_d.rsh = {s_q.rx_s, s_q.rsh[8:1]};
            s_d.rcnt = 4'(s_q.rcnt - 4'h1);
            s_d.rtmr = 20'(bit_cyc - 20'h00001);
            if (s_q.rcnt == 4'h1) begin
              s_d.rst = UBS_RX_STOP;
            end
          end
        end
        UBS_RX_STOP: begin
          if (s_q.rtmr != 20'h00000) begin
            s_d.rtmr = 20'(s_q.rtmr - 20'h00001);
          end else begin
            s_d.rst = UBS_RX_IDLE;
            if (!s_q.rx_s) begin
              s_d.rafe = 1'b1;
            end else begin
              s_d.rafe = 1'b0;
              push = 1'b1;
            end
          end
        end
        default: begin
          s_d.rst = UBS_RX_IDLE;
        end
      endcase
    end
    if (s_q.cfg.len7 && s_q.cfg.pe) begin
      rxw = {s_q.rsh[8], 1'b0, s_q.rsh[7:1]};
    end else if (s_q.cfg.len7) begin
      rxw = {1'b0, 1'b0, s_q.rsh[8:2]};
    end

    // Receive store pointers
    if (pop) begin
      s_d.rp = 4'(s_q.rp + 4'h1);
    end
    if (push) begin
      if (s_q.cfg.fifo_dis) begin
        wr = {1'b1, s_q.wp[2:0], rxw};
        s_d.rp = s_q.wp;
        s_d.wp = 4'(s_q.wp + 4'h1);
      end else if (cnt != 4'h8) begin
        wr = {1'b1, s_q.wp[2:0], rxw};
        s_d.wp = 4'(s_q.wp + 4'h1);
      end
    end
    if (clr) begin
      wr = '0;
      s_d.wp = 4'h0;
      s_d.rp = 4'h0;
    end

    // Receiver activity in shutdown wins over any clear
    if (shut && (s_q.rx_s != s_q.rx_p)) begin
      s_d.rafe = 1'b1;
    end

    // Transmitter
    if (shut && !s_q.hw_s) begin
      s_d.tst = UBS_TX_IDLE;
      s_d.txo = `UBS_RST_LINE;
    end else begin
      case (s_q.tst)
        UBS_TX_IDLE: begin
          if (!s_q.t && s_q.osc) begin
            if (s_q.cfg.pe) begin
              s_d.tsh = {2'h3, s_q.tbuf.extra, s_q.tbuf.data, 1'b0};
            end else begin
              s_d.tsh = {3'h7, s_q.tbuf.data, 1'b0};
            end
            if (s_q.cfg.len7) begin
              s_d.tsh = {s_d.tsh[10:8], s_d.tsh[8:0]} | 12'h800;
              s_d.tsh[8] = s_q.cfg.pe ? s_q.tbuf.extra : 1'b1;
            end
            s_d.tcnt = 4'(4'hA + {3'h0, s_q.cfg.pe} + {3'h0, s_q.cfg.st} - {3'h0, s_q.cfg.len7});
            s_d.t = 1'b1;
            s_d.ttmr = 20'(bit_cyc - 20'h00001);
            s_d.txo = 1'b0;
            s_d.tst = UBS_TX_SEND;
          end
        end
        UBS_TX_SEND: begin
          if (s_q.ttmr != 20'h00000) begin
            s_d.ttmr = 20'(s_q.ttmr - 20'h00001);
          end else begin
            s_d.tsh = {1'b1, s_q.tsh[11:1]};
            s_d.tcnt = 4'(s_q.tcnt - 4'h1);
            s_d.ttmr = 20'(bit_cyc - 20'h00001);
            s_d.txo = s_q.tsh[1];
            if (s_q.tcnt == 4'h1) begin
              s_d.txo = `UBS_RST_LINE;
              s_d.tst = UBS_TX_IDLE;
            end
          end
        end
        default: begin
          s_d.tst = UBS_TX_IDLE;
        end
      endcase
    end

    // Interrupt output
    s_d.irq_n = ~((s_q.cfg.tm & s_q.t) |
                  (s_q.cfg.rm & r_flag) |
                  (s_q.cfg.pm & rd_data.extra & r_flag) |
                  (s_q.cfg.ram & s_q.rafe));
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.spi_m.cs_n <= 1'b1;
      s_q.spi_s.cs_n <= 1'b1;
      s_q.spi_p.cs_n <= 1'b1;
      s_q.rx_m <= `UBS_RST_LINE;
      s_q.rx_s <= `UBS_RST_LINE;
      s_q.rx_p <= `UBS_RST_LINE;
      s_q.cts_m <= 1'b1;
      s_q.cts_s <= 1'b1;
      s_q.hw_m <= 1'b1;
      s_q.hw_s <= 1'b1;
      s_q.osc <= 1'b1;
      s_q.rts_n <= `UBS_RST_RTS_N;
      s_q.t <= `UBS_RST_TX_EMPTY;
      s_q.tst <= UBS_TX_IDLE;
      s_q.rst <= UBS_RX_IDLE;
      s_q.txo <= `UBS_RST_LINE;
      s_q.irq_n <= 1'b1;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign dout_o = s_q.dout;
  assign tx_o = s_q.txo;
  assign rts_n_o = s_q.rts_n;
  assign irq_n_o = s_q.irq_n;
  assign osc_run_o = s_q.osc;
  assign hardware_shutdown_pin_rb_o = s_q.hardware_shutdown_pin_rb;

endmodule : ubs_uart_core

//--- bench/ubs_uart_core_assertions.sv
// Port-level assertions of the serial UART core
`timescale 1ns/10ps
module ubs_uart_core_assertions #(
  parameter int unsigned WAKE_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire ubs_pkg::ubs_spi_t spi_i,
  input wire logic tx_o,
  input wire logic rts_n_o,
  input wire logic hw_hardware_shutdown_pin_n_i,
  input wire logic irq_n_o,
  input wire logic osc_run_o,
  input wire logic hardware_shutdown_pin_rb_o
);
  import ubs_pkg::*;
  localparam int WAKE_MAX = WAKE_CYC + 16;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_low_bit;
    !tx_o [*8] ##1 !tx_o [*8];
  endsequence
  sequence s_pin_held;
    !hw_hardware_shutdown_pin_n_i [*5];
  endsequence
  a_reset_state: assert property ($rose(arst_n_i) |-> tx_o && rts_n_o && irq_n_o && osc_run_o && !hardware_shutdown_pin_rb_o)
    else $error("outputs wrong after reset");
  a_hw_hardware_shutdown_pin_fast: assert property (s_pin_held |-> hardware_shutdown_pin_rb_o)
    else $error("pin shutdown readback late");
  a_shut_osc_stop: assert property ($rose(hardware_shutdown_pin_rb_o) |-> ##[0:3] !osc_run_o)
    else $error("oscillator still running in shutdown");
  a_shut_tx_idle: assert property ($rose(hardware_shutdown_pin_rb_o) && hw_hardware_shutdown_pin_n_i && $past(hw_hardware_shutdown_pin_n_i, 4) |-> tx_o)
    else $error("shutdown readback while sending");
  a_wake_bound: assert property ($fell(hardware_shutdown_pin_rb_o) |-> ##[0:WAKE_MAX] osc_run_o)
    else $error("oscillator did not restart");
  a_wake_delay_held: assert property ($fell(hardware_shutdown_pin_rb_o) |-> !osc_run_o [*8])
    else $error("oscillator restarted without wake delay");
  a_tx_bit_width: assert property ($fell(tx_o) |-> s_low_bit)
    else $error("low bit shorter than one period");
  a_rts_at_deselect: assert property ($changed(rts_n_o) |-> $past(spi_i.cs_n, 2))
    else $error("handshake output changed while selected");
  a_rts_hold_select: assert property (!spi_i.cs_n [*4] |=> $stable(rts_n_o))
    else $error("handshake output moved in frame");
endmodule : ubs_uart_core_assertions

bind ubs_uart_core ubs_uart_core_assertions #(.WAKE_CYC(WAKE_CYC)) u_chk (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .spi_i(spi_i),
  .tx_o(tx_o),
  .rts_n_o(rts_n_o),
  .hw_hardware_shutdown_pin_n_i(hw_hardware_shutdown_pin_n_i),
  .irq_n_o(irq_n_o),
  .osc_run_o(osc_run_o),
  .hardware_shutdown_pin_rb_o(hardware_shutdown_pin_rb_o)
);

//--- bench/ubs_host_model.sv
// Behavioural host on the serial port of the UART core
`timescale 1ns/10ps
module ubs_host_model (
  input wire logic sys_clk_i,
  input wire logic dout_i,
  output ubs_pkg::ubs_spi_t spi_o
);
  import ubs_pkg::*;
  initial spi_o = '{sclk: 1'h0, cs_n: 1'h1, din: 1'h0};
  // One 16-bit frame, MSB first, 160 ns serial clock
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      spi_o.cs_n <= 1'h0;
      spi_o.sclk <= 1'h0;
      spi_o.din <= w[i];
      repeat (4) @(posedge sys_clk_i);
      spi_o.sclk <= 1'h1;
      r[i] = dout_i;
      repeat (4) @(posedge sys_clk_i);
    end
    spi_o.cs_n <= 1'h1;
    spi_o.sclk <= 1'h0;
    spi_o.din <= ~w[0];
    repeat (6) @(posedge sys_clk_i);
  endtask : xfer
  // Configuration write, shutdown, transmit empty mask and stop select as given, other masks zero
  task automatic wr_cfg(input logic hardware_shutdown_pin, input logic tm, input logic two);
    logic [15:0] r;
    xfer({2'h3, 1'h0, hardware_shutdown_pin, tm, 4'h0, two, 6'h00}, r);
  endtask : wr_cfg
endmodule : ubs_host_model

//--- bench/ubs_uart_core_tb.sv
// Self-checking testbench of the serial UART core
`timescale 1ns/10ps
module ubs_uart_core_tb;
  import ubs_pkg::*;
  logic sys_clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  ubs_spi_t spi;
  logic dout, tx, rts_n, irq_n, osc, rb;
  logic rx_q = 1'h1;
  logic cts_n = 1'h1;
  logic hw_n = 1'h1;
  logic tx_d = 1'h1;
  logic [15:0] r;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int t_fall = 0;
  int gap = 0;
  int nfall = 0;
  wire [2:0] mon = {rb, osc, tx};
  always #10 sys_clk_i = ~sys_clk_i;
  ubs_uart_core #(.WAKE_CYC(20)) dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(1'h1), .spi_i(spi), .dout_o(dout),
    .rx_i(rx_q), .tx_o(tx), .cts_n_i(cts_n), .rts_n_o(rts_n), .hw_hardware_shutdown_pin_n_i(hw_n),
    .irq_n_o(irq_n), .osc_run_o(osc), .hardware_shutdown_pin_rb_o(rb)
  );
  ubs_host_model host (.sys_clk_i(sys_clk_i), .dout_i(dout), .spi_o(spi));
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    tx_d <= tx;
    if (tx_d && !tx) begin
      gap <= cyc - t_fall;
      t_fall <= cyc;
      nfall <= nfall + 1;
    end
  end
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_bit(input int k, input logic v, input int n);
    for (int i = 0; i < n && mon[k] !== v; i++) @(posedge sys_clk_i);
    if (mon[k] !== v) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_bit
  // Serial character on the receive line, 16 cycles a bit
  task automatic send_rx(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rx_q <= f[i];
      repeat (16) @(posedge sys_clk_i);
    end
    rx_q <= 1'h1;
    @(posedge sys_clk_i);
  endtask : send_rx
  task automatic t_reset();
    chk({tx, rts_n, irq_n, osc, rb}, 5'h1E);
    host.xfer(16'h4000, r);
    chk(r[14], 1'h1);
  endtask : t_reset
  task automatic t_mask();
    host.wr_cfg(1'h0, 1'h1, 1'h1);
    chk(irq_n, 1'h0);
    host.xfer(16'h4000, r);
    chk({r[11], r[6]}, 2'h3);
    host.wr_cfg(1'h0, 1'h0, 1'h0);
    chk(irq_n, 1'h1);
  endtask : t_mask
  task automatic t_stop(input logic two);
    host.wr_cfg(1'h0, 1'h0, two);
    host.xfer(16'h80FF, r);
    host.xfer(16'h80FF, r);
    host.xfer(16'h0000, r);
    chk(r[14], 1'h0);
    repeat (60) @(posedge sys_clk_i);
    chk(gap, two ? 16'h00B1 : 16'h00A1);
  endtask : t_stop
  task automatic t_inhibit();
    int n0;
    n0 = nfall;
    host.xfer(16'h86FF, r);
    repeat (40) @(posedge sys_clk_i);
    chk(nfall, n0);
    chk(rts_n, 1'h0);
  endtask : t_inhibit
  task automatic t_rx();
    cts_n <= 1'h0;
    send_rx(8'h3C, 1'h1);
    send_rx(8'hC3, 1'h1);
    host.xfer(16'h0000, r);
    chk(r, 16'hC23C);
    send_rx(8'h11, 1'h0);
    repeat (16) @(posedge sys_clk_i);
    host.xfer(16'h0000, r);
    chk(r, 16'hC6C3);
    host.xfer(16'h0000, r);
    chk(r, 16'h4600);
    send_rx(8'h22, 1'h1);
    host.xfer(16'h0000, r);
    chk(r, 16'hC222);
    send_rx(8'h33, 1'h0);
    repeat (16) @(posedge sys_clk_i);
    host.wr_cfg(1'h0, 1'h0, 1'h0);
    host.xfer(16'h0000, r);
    chk(r, 16'h4200);
  endtask : t_rx
  task automatic t_shut();
    send_rx(8'h44, 1'h1);
    host.xfer(16'h82FF, r);
    host.wr_cfg(1'h1, 1'h0, 1'h0);
    chk(rb, 1'h0);
    wait_bit(2, 1'h1, 80);
    chk(tx, 1'h1);
    repeat (4) @(posedge sys_clk_i);
    chk({osc, rts_n}, 2'h0);
    rx_q <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    rx_q <= 1'h1;
    repeat (8) @(posedge sys_clk_i);
    host.xfer(16'h0000, r);
    chk(r, 16'h0600);
    host.xfer(16'h4000, r);
    chk(r[12], 1'h1);
    host.wr_cfg(1'h0, 1'h0, 1'h0);
    wait_bit(1, 1'h1, 60);
    chk(rb, 1'h0);
    host.wr_cfg(1'h0, 1'h0, 1'h0);
    host.xfer(16'h0000, r);
    chk({r, rts_n}, 17'h08400);
  endtask : t_shut
  task automatic t_hw();
    send_rx(8'h55, 1'h1);
    hw_n <= 1'h0;
    repeat (5) @(posedge sys_clk_i);
    chk(rb, 1'h1);
    hw_n <= 1'h1;
    wait_bit(1, 1'h1, 60);
    chk(rb, 1'h0);
    host.xfer(16'h0000, r);
    chk(r, 16'h4200);
  endtask : t_hw
  initial begin
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    t_reset();
    t_mask();
    t_stop(1'h0);
    t_stop(1'h1);
    t_inhibit();
    t_rx();
    t_shut();
    t_hw();
    complete_run();
  end
endmodule : ubs_uart_core_tb
